/* rtl/serial_module_aux_regs.sv */
// shared control/status register bank of the dual channel serial module
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] rate_set_select one picks second baud group, zero the first
// [RULE2] three-bit field picks counter or timer mode and its clock source
// [RULE3] enabled input change flag sets status bit 7; disabled ones do not
// [RULE4] irq high when any status flag and its mask bit are both one
// [RULE5] status reads give true flags regardless of the mask
// [RULE6] all status bits clear on module reset; the rx and tx bits 0, 1, 4 and 5 follow the channel inputs instead
// [RULE7] input-change flag set by change on enabled input, else reads zero
// [RULE8] break-delta flag sets on start or end of a received break
// [RULE9] receive flag mirrors fifo-full or receiver-ready per mode bit 6
// [RULE10] transmit flag mirrors channel transmitter-ready bit
// [RULE11] stop-counter read clears counter ready in both modes
// [RULE12] start-counter read starts counter/timer; read data meaningless
// [RULE13] stop-counter read stops counter; counter mode clears output three
// [RULE14] current count readable as high and low bytes
// [RULE15] preload from write-only high/low bytes; software keeps it >= 0002
// [RULE16] 8-bit interrupt vector register resets to 0F
// [RULE17] input pins latched at read; unbonded inputs read one
// [RULE18] output three function: latch, counter out, B tx clock, B rx clock
// [RULE19] output two function: latch, A 16x tx, A 1x tx, A 1x rx clock
// [RULE20] bit-set write sets latch bits written one
// [RULE21] bit-clear write clears latch bits written one
// [RULE22] pins drive inverse of latch; latch resets to zero
// [RULE23] input change register read clears change flags and status flag
// [RULE24] break-change reset command clears break-delta flags
// [RULE25] status and mask bit order: cos, dbb, rxb, txb, ctr, dba, rxa, txa
module serial_module_aux_regs
  import serial_aux_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // channel status and clocks
  input wire chan_status_t chan_a,
  input wire chan_status_t chan_b,
  input wire logic tx_clock_a_16x,
  input wire logic tx_clock_a,
  input wire logic rx_clock_a,
  input wire logic tx_clock_b,
  input wire logic rx_clock_b,
  // port pins
  input wire logic [2:0] in_pins,
  input wire logic ext_clock_pin,
  output logic [7:0] out_pins,
  // interrupt and configuration
  output logic irq,
  output logic [7:0] int_vector_out,
  output logic rate_set_select
);

  function automatic logic hit(input logic [31:0] a, input logic [3:0] idx);
    hit = (a[31:6] == 26'h0) && (a[5:2] == idx);
  endfunction

  logic [7:0] aux_control, int_mask, int_vector, preload_high, preload_low;
  logic [7:0] outport_config, outport_latch, int_status;
  logic [2:0] input_change_flag;
  logic cos_sel, break_delta_a, break_delta_b, rx_flag_a, rx_flag_b, ct_ready, ct_run, ct_out;
  logic [15:0] ct_count;
  logic [3:0] ct_presc;
  ct_src_t ct_mode_source;

  // ---------------- pin synchronisers ----------------
  logic [3:0] sync1, sync2, sync_prev;
  logic sync_seen, tx_a_prev, tx_b_prev;
  logic [1:0] warm_up;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync_prev[g] <= 1'b0;
        end else begin
          sync1[g] <= (g == 3) ? ext_clock_pin : in_pins[g % 3];
          sync2[g] <= sync1[g];
          sync_prev[g] <= sync2[g];
        end
      end
    end
  endgenerate

  // sync and compare stages hold reset zeros for three edges, so a high pin is no change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_seen <= 1'b0;
      warm_up <= 2'h0;
      tx_a_prev <= 1'b0;
      tx_b_prev <= 1'b0;
    end else begin
      sync_seen <= warm_up[1];
      warm_up <= {warm_up[0], 1'b1};
      tx_a_prev <= tx_clock_a;
      tx_b_prev <= tx_clock_b;
    end
  end

  // ---------------- axi4-lite slave ----------------
  wr_state_t wr_state;
  logic aw_held, w_held, w_lane0_q, have_aw, have_w, do_write, wr_lane0, rd_take;
  logic [31:0] aw_addr_q, w_data_q, wr_addr, wr_data;

  assign awready = (wr_state == WR_IDLE) && !aw_held;
  assign wready = (wr_state == WR_IDLE) && !w_held;
  assign bvalid = (wr_state == WR_RESP);
  assign have_aw = aw_held || (awvalid && awready);
  assign have_w = w_held || (wvalid && wready);
  assign do_write = (wr_state == WR_IDLE) && have_aw && have_w;
  assign wr_addr = aw_held ? aw_addr_q : awaddr;
  assign wr_data = w_held ? w_data_q : wdata;
  assign wr_lane0 = w_held ? w_lane0_q : wstrb[0];
  assign arready = !rvalid;
  assign rd_take = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 32'h0;
      w_data_q <= 32'h0;
      w_lane0_q <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready && !do_write) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready && !do_write) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_lane0_q <= wstrb[0];
      end
      case (wr_state)
        WR_IDLE: begin
          if (do_write) begin
            wr_state <= WR_RESP;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bresp <= (wr_addr[31:6] == 26'h0) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  // only byte lane 0 carries register data
  function automatic logic wr_hit(input logic [3:0] idx);
    wr_hit = do_write && wr_lane0 && hit(wr_addr, idx);
  endfunction

  logic rd_icr, rd_start, rd_stop;
  assign rd_icr = rd_take && hit(araddr, IDX_INPUT_CHANGE);
  assign rd_start = rd_take && hit(araddr, IDX_COUNTER_START);
  assign rd_stop = rd_take && hit(araddr, IDX_COUNTER_STOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rresp <= (araddr[31:6] == 26'h0) ? RESP_OKAY : RESP_SLVERR;
      rdata <= 32'h0;
      if (araddr[31:6] == 26'h0) begin
        case (araddr[5:2])
          IDX_AUX_CONTROL: rdata[7:0] <= aux_control;
          IDX_INT_STATUS: rdata[7:0] <= int_status; // [RULE5]
          IDX_INT_MASK: rdata[7:0] <= int_mask;
          IDX_COUNT_NOW_HIGH: rdata[7:0] <= ct_count[15:8]; // [RULE14]
          IDX_COUNT_NOW_LOW: rdata[7:0] <= ct_count[7:0]; // [RULE14]
          IDX_INT_VECTOR: rdata[7:0] <= int_vector;
          IDX_INPUT_PINS: rdata[7:0] <= {2'h0, IP_UNBONDED, sync2[2:0]}; // [RULE17]
          IDX_INPUT_CHANGE: rdata[7:0] <= {1'b0, input_change_flag, 1'b0, sync2[2:0]};
          default: rdata <= 32'h0; // write-only and command words read zero [RULE12] [RULE15]
        endcase
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_control <= REG_RESET;
      int_mask <= REG_RESET;
      int_vector <= INT_VECTOR_RESET; // [RULE16]
      outport_config <= REG_RESET;
    end else begin
      if (wr_hit(IDX_AUX_CONTROL)) aux_control <= wr_data[7:0];
      if (wr_hit(IDX_INT_MASK)) int_mask <= wr_data[7:0];
      if (wr_hit(IDX_INT_VECTOR)) int_vector <= wr_data[7:0];
      if (wr_hit(IDX_OUTPORT_CONFIG)) outport_config <= wr_data[7:0];
    end
  end

  // preload below 0002 is not guarded; software keeps it legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preload_high <= REG_RESET;
      preload_low <= REG_RESET;
    end else begin
      if (wr_hit(IDX_PRELOAD_HIGH)) preload_high <= wr_data[7:0]; // [RULE15]
      if (wr_hit(IDX_PRELOAD_LOW)) preload_low <= wr_data[7:0]; // [RULE15]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outport_latch <= LATCH_RESET; // [RULE22]
    end else if (wr_hit(IDX_OUTPORT_BIT_SET)) begin
      outport_latch <= outport_latch | wr_data[7:0]; // [RULE20]
    end else if (wr_hit(IDX_OUTPORT_BIT_CLEAR)) begin
      outport_latch <= outport_latch & ~wr_data[7:0]; // [RULE21]
    end
  end

  assign ct_mode_source = ct_src_t'(aux_control[ACR_CTMS_LO +: 3]);
  assign rate_set_select = aux_control[ACR_RATE_SEL]; // [RULE1]
  assign int_vector_out = int_vector;

  // ---------------- input change flags ----------------
  generate
    for (g = 0; g < 3; g++) begin : g_cos
      // a change in the clearing read's cycle is kept
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          input_change_flag[g] <= 1'b0;
        end else if (sync_seen && (sync2[g] != sync_prev[g])) begin
          input_change_flag[g] <= 1'b1;
        end else if (rd_icr) begin
          input_change_flag[g] <= 1'b0; // [RULE23]
        end
      end
    end
  endgenerate

  assign cos_sel = |(input_change_flag & aux_control[ACR_IEC_LO +: 3]); // [RULE3] [RULE7]

  // ---------------- break delta flags ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_delta_a <= 1'b0; // [RULE6]
      break_delta_b <= 1'b0; // [RULE6]
    end else begin
      if (chan_a.break_edge) break_delta_a <= 1'b1; // [RULE8]
      else if (chan_a.break_reset) break_delta_a <= 1'b0; // [RULE24]
      if (chan_b.break_edge) break_delta_b <= 1'b1; // [RULE8]
      else if (chan_b.break_reset) break_delta_b <= 1'b0; // [RULE24]
    end
  end

  assign rx_flag_a = chan_a.rx_select ? chan_a.rx_fifo_full : chan_a.rx_ready; // [RULE9]
  assign rx_flag_b = chan_b.rx_select ? chan_b.rx_fifo_full : chan_b.rx_ready; // [RULE9]

  assign int_status = {cos_sel, break_delta_b, rx_flag_b, chan_b.tx_ready, // [RULE25]
                       ct_ready, break_delta_a, rx_flag_a, chan_a.tx_ready}; // [RULE10]

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(int_status & int_mask); // [RULE4]
  end

  // ---------------- counter/timer ----------------
  logic pre_edge, use_presc, raw_tick, ct_tick, ct_is_timer, ct_terminal;

  assign ct_is_timer = ct_mode_source[2];

  always_comb begin
    pre_edge = 1'b0;
    use_presc = 1'b0;
    case (ct_mode_source) // [RULE2]
      CT_CNT_IP2, CT_TMR_IP2: pre_edge = sync2[2] && !sync_prev[2];
      CT_CNT_TXA: pre_edge = tx_clock_a && !tx_a_prev;
      CT_CNT_TXB: pre_edge = tx_clock_b && !tx_b_prev;
      CT_CNT_XTAL, CT_TMR_XTAL: pre_edge = 1'b1;
      CT_TMR_IP2_DIV: begin
        pre_edge = sync2[2] && !sync_prev[2];
        use_presc = 1'b1;
      end
      CT_TMR_EXT_DIV: begin
        pre_edge = sync2[3] && !sync_prev[3];
        use_presc = 1'b1;
      end
      default: pre_edge = 1'b0;
    endcase
  end

  assign raw_tick = use_presc ? (pre_edge && (ct_presc == 4'(CT_PRESCALE - 1))) : pre_edge;
  assign ct_tick = ct_run && raw_tick;
  assign ct_terminal = ct_tick && (ct_count == 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) ct_presc <= 4'h0;
    else if (rd_start) ct_presc <= 4'h0;
    else if (pre_edge && use_presc) ct_presc <= ct_presc + 4'h1;
  end

  // counter wraps through FFFF after terminal; timer reloads for a square wave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_run <= 1'b0;
      ct_count <= 16'h0;
      ct_out <= 1'b0;
    end else if (rd_start) begin
      ct_run <= 1'b1; // [RULE12]
      ct_count <= {preload_high, preload_low};
      ct_out <= 1'b0;
    end else if (rd_stop && !ct_is_timer) begin
      ct_run <= 1'b0; // [RULE13]
      ct_out <= 1'b0; // [RULE13]
    end else if (ct_terminal && ct_is_timer) begin
      ct_count <= {preload_high, preload_low};
      ct_out <= !ct_out;
    end else if (ct_tick) begin
      ct_count <= ct_count - 16'h0001;
      if (ct_terminal) ct_out <= 1'b1;
    end
  end

  // ready set wins over the stop read that clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_ready <= 1'b0; // [RULE6]
    end else if (ct_terminal && (!ct_is_timer || ct_out)) begin
      ct_ready <= 1'b1;
    end else if (rd_stop) begin
      ct_ready <= 1'b0; // [RULE11]
    end
  end

  // ---------------- output port ----------------
  logic [7:0] next_out_pins;

  always_comb begin
    next_out_pins = ~outport_latch; // [RULE22]
    case (outport_config[OPCR_OP3_LO +: 2]) // [RULE18]
      2'h0: next_out_pins[3] = ~outport_latch[3];
      2'h1: next_out_pins[3] = ct_out;
      2'h2: next_out_pins[3] = tx_clock_b;
      2'h3: next_out_pins[3] = rx_clock_b;
      default: next_out_pins[3] = ~outport_latch[3];
    endcase
    case (outport_config[OPCR_OP2_LO +: 2]) // [RULE19]
      2'h0: next_out_pins[2] = ~outport_latch[2];
      2'h1: next_out_pins[2] = tx_clock_a_16x;
      2'h2: next_out_pins[2] = tx_clock_a;
      2'h3: next_out_pins[2] = rx_clock_a;
      default: next_out_pins[2] = ~outport_latch[2];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) out_pins <= ~LATCH_RESET;
    else out_pins <= next_out_pins;
  end

endmodule

`default_nettype wire

/* rtl/serial_aux_pkg.sv */
// shared constants and types for the serial module auxiliary register bank
package serial_aux_pkg;

  // register word indices; byte address is four times the index
  localparam logic [3:0] IDX_AUX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_INT_STATUS = 4'h1;
  localparam logic [3:0] IDX_INT_MASK = 4'h2;
  localparam logic [3:0] IDX_COUNT_NOW_HIGH = 4'h3;
  localparam logic [3:0] IDX_COUNT_NOW_LOW = 4'h4;
  localparam logic [3:0] IDX_PRELOAD_HIGH = 4'h5;
  localparam logic [3:0] IDX_PRELOAD_LOW = 4'h6;
  localparam logic [3:0] IDX_INT_VECTOR = 4'h7;
  localparam logic [3:0] IDX_INPUT_PINS = 4'h8;
  localparam logic [3:0] IDX_OUTPORT_CONFIG = 4'h9;
  localparam logic [3:0] IDX_COUNTER_START = 4'hA;
  localparam logic [3:0] IDX_COUNTER_STOP = 4'hB;
  localparam logic [3:0] IDX_INPUT_CHANGE = 4'hC;
  localparam logic [31:0] PRINTED_BIT_SET = 32'hFFFFF7FD;
  localparam logic [31:0] PRINTED_BIT_CLEAR = 32'h0FFFF7FF;
  localparam logic [3:0] IDX_OUTPORT_BIT_SET = PRINTED_BIT_SET[3:0];
  localparam logic [3:0] IDX_OUTPORT_BIT_CLEAR = PRINTED_BIT_CLEAR[3:0];

  // aux_control fields
  localparam int ACR_RATE_SEL = 7;
  localparam int ACR_CTMS_LO = 4;
  localparam int ACR_IEC_LO = 0;

  // outport_config fields
  localparam int OPCR_OP3_LO = 2;
  localparam int OPCR_OP2_LO = 0;

  // reset values, unbonded input level and counter prescale
  localparam logic [7:0] INT_VECTOR_RESET = 8'h0F;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] IP_UNBONDED = 3'h7;
  localparam int CT_PRESCALE = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CT_CNT_IP2 = 3'h0,
    CT_CNT_TXA = 3'h1,
    CT_CNT_TXB = 3'h2,
    CT_CNT_XTAL = 3'h3,
    CT_TMR_IP2 = 3'h4,
    CT_TMR_IP2_DIV = 3'h5,
    CT_TMR_XTAL = 3'h6,
    CT_TMR_EXT_DIV = 3'h7
  } ct_src_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef struct packed {
    logic tx_ready;
    logic rx_ready;
    logic rx_fifo_full;
    logic rx_select;
    logic break_edge;
    logic break_reset;
  } chan_status_t;

endpackage

/* tb/serial_aux_sva.sv */
// port-level assertion checker for the serial auxiliary register bank
`timescale 1ns/1ps
`default_nettype none
module serial_aux_sva
  import serial_aux_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // pins
  input wire logic [7:0] out_pins,
  input wire logic irq,
  input wire logic [7:0] int_vector_out,
  input wire logic rate_set_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam logic [31:0] A_SET = {26'h0, IDX_OUTPORT_BIT_SET, 2'b00};
  localparam logic [31:0] A_CLR = {26'h0, IDX_OUTPORT_BIT_CLEAR, 2'b00};
  // write checks assume address and data taken on one edge
  wire ar_go = arvalid && arready;
  wire w_go = awvalid && awready && wvalid && wready && wstrb[0];

  rst_values_a: assert property (disable iff (1'b0) !aresetn |=>
    out_pins == 8'hFF && int_vector_out == INT_VECTOR_RESET && !irq)
    else $error("reset values wrong");
  rate_read_a: assert property (ar_go && araddr == 32'h0 |=> rdata[7] == rate_set_select)
    else $error("rate select differs from register");
  vec_read_a: assert property (ar_go && araddr == 32'h1C |=> rdata[7:0] == int_vector_out)
    else $error("vector output differs from register");
  start_data_a: assert property (ar_go && araddr == 32'h28 |=> rdata == 32'h0)
    else $error("start command read data not zero");
  preload_wo_a: assert property (ar_go && araddr inside {32'h14, 32'h18} |=> rdata == 32'h0)
    else $error("preload register readable");
  pins_high_a: assert property (ar_go && araddr == 32'h20 |=> rdata[7:3] == 5'h07)
    else $error("unbonded inputs not one");
  out_set_a: assert property (w_go && awaddr == A_SET && wdata[0] |-> ##[1:3] !out_pins[0])
    else $error("bit set did not drive pin low");
  out_clr_a: assert property (w_go && awaddr == A_CLR && wdata[0] |-> ##[1:3] out_pins[0])
    else $error("bit clear did not drive pin high");
  slverr_a: assert property (ar_go && araddr[31:6] != 26'h0 |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");

  cover property (w_go && awaddr == A_SET);
  cover property ($rose(irq));
  cover property (ar_go && araddr == 32'h2C);
endmodule

bind serial_module_aux_regs serial_aux_sva u_serial_aux_sva (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .out_pins(out_pins),
  .irq(irq), .int_vector_out(int_vector_out), .rate_set_select(rate_set_select)
);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the serial auxiliary register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import serial_aux_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, rate_set_select;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] out_pins, int_vector_out;
  chan_status_t chan_a = '0, chan_b = '0;
  // {ext, rx b, tx b, rx a, tx a, tx a 16x}
  logic [5:0] ck = 6'h00;
  logic [2:0] in_pins = 3'h0;
  int fail_count = 0;
  int cmp_count = 0;

  serial_module_aux_regs u_serial_module_aux_regs (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .chan_a(chan_a),
    .chan_b(chan_b), .tx_clock_a_16x(ck[0]), .tx_clock_a(ck[1]), .rx_clock_a(ck[2]),
    .tx_clock_b(ck[3]), .rx_clock_b(ck[4]), .in_pins(in_pins), .ext_clock_pin(ck[5]),
    .out_pins(out_pins), .irq(irq), .int_vector_out(int_vector_out),
    .rate_set_select(rate_set_select)
  );

  initial forever #5 aclk = ~aclk;

  function automatic logic [31:0] ad(input logic [3:0] i);
    return {26'h0, i, 2'b00};
  endfunction
  function automatic logic [7:0] stat(input chan_status_t a, input chan_status_t b);
    return {2'b00, b.rx_select ? b.rx_fifo_full : b.rx_ready, b.tx_ready, 2'b00,
      a.rx_select ? a.rx_fifo_full : a.rx_ready, a.tx_ready};
  endfunction
  function automatic logic [1:0] opx(input logic [1:0] k, input logic [7:0] l, input logic [5:0] c);
    logic o3;
    logic o2;
    o3 = k == 2'h0 ? ~l[3] : k == 2'h1 ? 1'b0 : k == 2'h2 ? c[3] : c[4];
    o2 = k == 2'h0 ? ~l[2] : k == 2'h1 ? c[0] : k == 2'h2 ? c[1] : c[2];
    return {o3, o2};
  endfunction

  task automatic results;
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic late;
    late = 1'($urandom);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    // a late ready lets the answer stand unacknowledged for a cycle
    if (late) begin
      @(posedge aclk);
      bready <= 1'b1;
    end
    do @(posedge aclk); while (!(bvalid && bready));
    rr = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a);
    logic late;
    late = 1'($urandom);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    if (late) begin
      @(posedge aclk);
      rready <= 1'b1;
    end
    do @(posedge aclk); while (!(rvalid && rready));
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input string n, input logic [3:0] i, input logic [31:0] e);
    rd(ad(i));
    chk(n, e, rv);
  endtask
  task automatic pulse(input logic [5:0] a, input logic [5:0] b);
    chan_a <= chan_status_t'(a);
    chan_b <= chan_status_t'(b);
    @(posedge aclk);
    chan_a <= '0;
    chan_b <= '0;
  endtask

  // long enough for every scenario, short enough to catch a hang
  initial begin
    #200000;
    fail_count++;
    results();
  end

  initial begin
    logic [7:0] v;
    v = 8'($urandom(32'h2FA38BED));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("out_pins", 32'hFF, {24'h0, out_pins});
    chk("int_vector_out", 32'h0F, {24'h0, int_vector_out});
    rc("int_status", IDX_INT_STATUS, 32'h0);
    rc("int_vector", IDX_INT_VECTOR, 32'h0F);
    v = 8'($urandom);
    wr(ad(IDX_INT_VECTOR), v);
    chk("int_vector_out", {24'h0, v}, {24'h0, int_vector_out});
    wr(ad(IDX_AUX_CONTROL), 8'h80);
    chk("rate_set_select", 32'h1, {31'h0, rate_set_select});
    rc("aux_control", IDX_AUX_CONTROL, 32'h80);
    wr(ad(IDX_AUX_CONTROL), 8'h01);
    chk("rate_set_select", 32'h0, {31'h0, rate_set_select});
    repeat (12) begin
      chan_a <= chan_status_t'(6'($urandom) & 6'h3C);
      chan_b <= chan_status_t'(6'($urandom) & 6'h3C);
      v = 8'($urandom);
      wr(ad(IDX_INT_MASK), v);
      chk("irq", {31'h0, |(stat(chan_a, chan_b) & v)}, {31'h0, irq});
      rc("int_status", IDX_INT_STATUS, {24'h0, stat(chan_a, chan_b)});
    end
    pulse(6'h02, 6'h00);
    rc("int_status", IDX_INT_STATUS, 32'h04);
    pulse(6'h00, 6'h02);
    rc("int_status", IDX_INT_STATUS, 32'h44);
    pulse(6'h01, 6'h01);
    rc("int_status", IDX_INT_STATUS, 32'h00);
    in_pins <= 3'h2;
    repeat (6) @(posedge aclk);
    rc("int_status", IDX_INT_STATUS, 32'h00);
    rc("input_change", IDX_INPUT_CHANGE, 32'h22);
    in_pins <= 3'h3;
    repeat (6) @(posedge aclk);
    rc("int_status", IDX_INT_STATUS, 32'h80);
    rc("input_change", IDX_INPUT_CHANGE, 32'h13);
    rc("int_status", IDX_INT_STATUS, 32'h00);
    v = 8'($urandom);
    in_pins <= v[2:0];
    repeat (6) @(posedge aclk);
    rc("input_pins", IDX_INPUT_PINS, {26'h0, 3'h7, v[2:0]});
    rd(ad(IDX_INPUT_CHANGE));
    wr(ad(IDX_OUTPORT_BIT_SET), 8'hA5);
    chk("out_pins", 32'h5A, {24'h0, out_pins});
    wr(ad(IDX_OUTPORT_BIT_CLEAR), 8'h21);
    chk("out_pins", 32'h7B, {24'h0, out_pins});
    for (int j = 0; j < 8; j++) begin
      ck <= 6'($urandom);
      wr(ad(IDX_OUTPORT_CONFIG), {4'h0, j[1:0], j[1:0]});
      chk("out_pins_3_2", {30'h0, opx(j[1:0], 8'h84, ck)}, {30'h0, out_pins[3:2]});
    end
    // minimum preload, counter clocked every cycle
    wr(ad(IDX_OUTPORT_CONFIG), 8'h04);
    wr(ad(IDX_PRELOAD_HIGH), 8'h00);
    wr(ad(IDX_PRELOAD_LOW), 8'h02);
    wr(ad(IDX_AUX_CONTROL), {1'b0, CT_CNT_XTAL, 4'h0});
    rc("counter_start", IDX_COUNTER_START, 32'h0);
    repeat (8) @(posedge aclk);
    rc("int_status", IDX_INT_STATUS, 32'h08);
    chk("out_pins_3", 32'h1, {31'h0, out_pins[3]});
    rc("counter_stop", IDX_COUNTER_STOP, 32'h0);
    rc("int_status", IDX_INT_STATUS, 32'h00);
    chk("out_pins_3", 32'h0, {31'h0, out_pins[3]});
    wr(ad(IDX_PRELOAD_HIGH), 8'h12);
    wr(ad(IDX_PRELOAD_LOW), 8'hF0);
    rd(ad(IDX_COUNTER_START));
    rd(ad(IDX_COUNTER_STOP));
    rc("count_now_high", IDX_COUNT_NOW_HIGH, 32'h12);
    rd(ad(IDX_COUNT_NOW_LOW));
    v = rv[7:0];
    chk("count_now_low_range", 32'h1, {31'h0, v < 8'hF0 && v > 8'hE0});
    rc("count_now_low", IDX_COUNT_NOW_LOW, {24'h0, v});
    rc("preload_low", IDX_PRELOAD_LOW, 32'h0);
    rd(32'h100);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    wr(32'h100, 8'hFF);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    // timer from the crystal, minimum preload: ready every second toggle
    wr(ad(IDX_PRELOAD_HIGH), 8'h00);
    wr(ad(IDX_PRELOAD_LOW), 8'h02);
    wr(ad(IDX_AUX_CONTROL), {1'b0, CT_TMR_XTAL, 4'h0});
    rd(ad(IDX_COUNTER_START));
    repeat (8) @(posedge aclk);
    rc("int_status_timer", IDX_INT_STATUS, 32'h08);
    // reset in mid-run with flags, vector and timer all live
    pulse(6'h02, 6'h02);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("out_pins", 32'hFF, {24'h0, out_pins});
    chk("int_vector_out", 32'h0F, {24'h0, int_vector_out});
    rc("int_status", IDX_INT_STATUS, 32'h0);
    results();
  end
endmodule
`default_nettype wire
